// *** design/wsb_beacon_sequencer.sv ***
`timescale 1ns/1ps
// Functional notes
// R1: a message is 162 symbols, each 0..3, selecting the tone.
// R2: tones are spaced 12000/8192 Hz; symbol k sits k spacings up.
// R3: each symbol lasts the reciprocal of the spacing, about 0.683 s.
// R4: message sends start only on an even minute of the clock; cw sends start on any slot minute, odd or even.
// R5: configured frequency is the frequency of tone zero.
// R6: payload holds callsign, 4-character grid and two-digit power.
// R7: while sending, show current symbol index and tone.
// R8: between sends, show running time and next start minute.
// R9: second pulse from the gps measures frequency error.
// R10: gps time sets the clock; grid comes from latitude/longitude.
// R11: one message keeps the transmitter keyed for 1 min 52 s.
// R12: gps data is parsed only after a send ends.
// R13: a 4 s window after each send measures the reference.
// R14: all post-send parsing and adjusting ends within 7 s.
// R15: the user should not pick a 2 minute repetition period.
// R16: the gps must be detached when used as a plain transceiver.
// R17: with beacon enabled, beacon mode starts right after power-up.
// R18: exit button cancels the beacon at once, even mid-send.
// R19: leaving the menu enters beacon mode if beacon is enabled.
// R20: transmitter stays keyed continuously through a message.
// R21: a cw beacon mode is selectable besides the tone mode.
// R22: cw mode repeats stored message 1 at the keyer speed.
// R23: first start at offset minute, later ones a period apart.
// R24: setting the clock applies the time and zeroes the seconds.
// R25: cancel unkeys, drops remaining symbols, never resumes.
// R26: symbol timing accumulates no drift over 162 symbols.
module wsb_beacon_sequencer #(
	parameter longint SYM_ACC_LIM = wsb_pkg::SYM_ACC_LIM_DEF,
	parameter int SEC_CYC = wsb_pkg::SEC_CYC_DEF,
	parameter int DIT_LIM = wsb_pkg::DIT_LIM_DEF
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic button_exit,
	input wire logic menu_exit,
	input wire logic beacon_enable_nv,
	input wire logic gps_valid,
	input wire logic [7:0] gps_byte,
	input wire logic gps_second_pulse,
	output logic tx_key,
	output logic [wsb_pkg::TONE_W-1:0] tone_word,
	output logic [7:0] sym_idx,
	output logic [1:0] sym_tone,
	output logic beacon_active,
	output logic [4:0] time_hh,
	output logic [5:0] time_mm,
	output logic [5:0] time_ss,
	output logic [5:0] next_min,
	output logic [31:0] ref_err
);
	import wsb_pkg::*;

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	logic [31:0] ctrl_r, ctrl_nxt;
	logic [31:0] freq_r, freq_nxt;
	logic [31:0] call_hi_r, call_hi_nxt;
	logic [31:0] call_lo_r, call_lo_nxt;
	logic [31:0] grid_r, grid_nxt;
	logic [31:0] power_r, power_nxt;
	logic [31:0] cwpat_r, cwpat_nxt;
	logic [31:0] cwcfg_r, cwcfg_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] sym_mem [0:SYM_COUNT-1];
	wsb_state_e st_r, st_nxt;
	logic [7:0] idx_r, idx_nxt;
	logic [1:0] tone_r, tone_nxt;
	logic key_r, key_nxt;
	logic [SACC_W-1:0] sacc_r, sacc_nxt;
	logic [6:0] tsec_r, tsec_nxt;
	logic [5:0] nmin_r, nmin_nxt;
	logic [2:0] post_r, post_nxt;
	logic [4:0] cwi_r, cwi_nxt;
	logic [31:0] dacc_r, dacc_nxt;
	logic boot_r, boot_nxt;
	logic [TONE_W-1:0] word_r, word_nxt;
	logic pps_d_r, pps_d_nxt;
	logic pps_seen_r, pps_seen_nxt;
	logic [31:0] pcnt_r, pcnt_nxt;
	logic [31:0] perr_r, perr_nxt;
	logic [4:0] hh;
	logic [5:0] mm, ss;
	logic sec_tick;
	logic time_set;
	logic meas_on;
	logic cw_mode;
	logic [5:0] frame;
	logic [5:0] start_min;
	logic [5:0] wpm;
	logic [4:0] cw_last;
	logic sym_wr;

	wsb_gps_if gif ();

	assign cw_mode = ctrl_r[0];
	assign frame = ctrl_r[13:8];
	assign start_min = ctrl_r[21:16];
	assign wpm = cwcfg_r[13:8];
	assign cw_last = cwcfg_r[4:0];
	assign time_set = reg_wr && reg_addr == A_TIME;
	assign sym_wr = reg_wr && reg_addr == A_SYMW;

	// --------------------------------------------------------------
	// clock and gps
	// --------------------------------------------------------------
	// parser is gated here so that bytes on the shared pins during a
	// send are never taken as time or position
	assign gif.parse_en = st_r == WSB_POST; // R12

	wsb_gps_parser u_gps (
		.clock(clock),
		.rst(rst),
		.clk_en(clk_en),
		.gps_valid(gps_valid),
		.gps_byte(gps_byte),
		.gif(gif)
	);

	wsb_rtc #(
		.SEC_CYC(SEC_CYC)
	) u_rtc (
		.clock(clock),
		.rst(rst),
		.clk_en(clk_en),
		.set(time_set), // R24
		.set_hh(reg_wdata[20:16]),
		.set_mm(reg_wdata[13:8]),
		.load(gif.upd), // R10
		.load_hh(gif.hh),
		.load_mm(gif.mm),
		.load_ss(gif.ss),
		.hh_r(hh),
		.mm_r(mm),
		.ss_r(ss),
		.tick_r(sec_tick)
	);

	// --------------------------------------------------------------
	// register file
	// --------------------------------------------------------------
	always_comb begin
		ctrl_nxt = ctrl_r;
		freq_nxt = freq_r;
		call_hi_nxt = call_hi_r;
		call_lo_nxt = call_lo_r;
		grid_nxt = grid_r;
		power_nxt = power_r;
		cwpat_nxt = cwpat_r;
		cwcfg_nxt = cwcfg_r;
		rdata_nxt = 32'h0;
		if (reg_wr) begin
			case (reg_addr)
				A_CTRL: ctrl_nxt = reg_wdata & 32'h003F_3F01;
				A_FREQ: freq_nxt = {4'h0, reg_wdata[FREQ_W-1:0]};
				A_CALL_HI: call_hi_nxt = {16'h0, reg_wdata[15:0]}; // R6
				A_CALL_LO: call_lo_nxt = reg_wdata; // R6
				A_GRID: grid_nxt = reg_wdata; // R6
				A_POWER: power_nxt = {25'h0, reg_wdata[6:0]}; // R6
				A_CWPAT: cwpat_nxt = reg_wdata;
				A_CWCFG: cwcfg_nxt = reg_wdata & 32'h0000_3F1F;
				default: ;
			endcase
		end
		// a fresh fix overrides a grid typed in by hand
		if (gif.upd) begin
			grid_nxt = gif.grid; // R10
		end
		if (reg_rd) begin
			case (reg_addr)
				A_CTRL: rdata_nxt = ctrl_r;
				A_FREQ: rdata_nxt = freq_r;
				A_CALL_HI: rdata_nxt = call_hi_r;
				A_CALL_LO: rdata_nxt = call_lo_r;
				A_GRID: rdata_nxt = grid_r;
				A_POWER: rdata_nxt = power_r;
				A_CWPAT: rdata_nxt = cwpat_r;
				A_CWCFG: rdata_nxt = cwcfg_r;
				A_TIME: rdata_nxt = {11'h0, hh, 2'h0, mm, 2'h0, ss}; // R8
				A_STATUS: rdata_nxt = {2'h0, nmin_r, 6'h0, tone_r, idx_r,
					3'h0, key_r, 1'b0, st_r}; // R7 R8
				A_REFERR: rdata_nxt = perr_r; // R9
				default: rdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_r <= CTRL_RST;
			freq_r <= FREQ_RST;
			call_hi_r <= 32'h0;
			call_lo_r <= 32'h0;
			grid_r <= 32'h0;
			power_r <= POWER_RST;
			cwpat_r <= 32'h0;
			cwcfg_r <= CWCFG_RST;
			rdata_r <= 32'h0;
		end else if (clk_en) begin
			ctrl_r <= ctrl_nxt;
			freq_r <= freq_nxt;
			call_hi_r <= call_hi_nxt;
			call_lo_r <= call_lo_nxt;
			grid_r <= grid_nxt;
			power_r <= power_nxt;
			cwpat_r <= cwpat_nxt;
			cwcfg_r <= cwcfg_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// symbol store, loaded by software with the encoded message
	always_ff @(posedge clock) begin
		if (clk_en && sym_wr && reg_wdata[23:16] < 8'(SYM_COUNT)) begin
			sym_mem[reg_wdata[23:16]] <= reg_wdata[1:0]; // R1
		end
	end

	// --------------------------------------------------------------
	// sequencer
	// --------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		idx_nxt = idx_r;
		tone_nxt = tone_r;
		key_nxt = key_r;
		sacc_nxt = sacc_r;
		tsec_nxt = tsec_r;
		nmin_nxt = nmin_r;
		post_nxt = post_r;
		cwi_nxt = cwi_r;
		dacc_nxt = dacc_r;
		boot_nxt = 1'b0;
		case (st_r)
			WSB_OFF: begin
				if ((boot_r || menu_exit) && beacon_enable_nv) begin
					st_nxt = WSB_WAIT; // R17 R19
					nmin_nxt = start_min; // R23
				end
			end
			WSB_WAIT: begin
				if (sec_tick && ss == 6'd0 && mm == nmin_r) begin
					nmin_nxt = wsb_add_min(nmin_r, frame); // R23
					idx_nxt = 8'd0;
					sacc_nxt = '0;
					tsec_nxt = 7'd0;
					cwi_nxt = 5'd0;
					dacc_nxt = 32'd0;
					if (cw_mode) begin
						st_nxt = WSB_CW; // R21
						key_nxt = cwpat_r[0];
					end else if (!mm[0]) begin
						st_nxt = WSB_WSPR; // R4
						key_nxt = 1'b1;
						tone_nxt = sym_mem[0];
					end
				end
			end
			WSB_WSPR: begin
				key_nxt = 1'b1; // R20
				// exact rational step: no drift however long the message
				if (sacc_r + SACC_W'(SPACING_NUM_HZ) >=
					SACC_W'(SYM_ACC_LIM)) begin
					sacc_nxt = sacc_r + SACC_W'(SPACING_NUM_HZ)
						- SACC_W'(SYM_ACC_LIM); // R3 R26
					if (idx_r < 8'(SYM_COUNT - 1)) begin
						idx_nxt = idx_r + 8'd1; // R1
						tone_nxt = sym_mem[idx_r + 8'd1];
					end
				end else begin
					sacc_nxt = sacc_r + SACC_W'(SPACING_NUM_HZ);
				end
				if (sec_tick) begin
					tsec_nxt = tsec_r + 7'd1;
					if (tsec_r == 7'(TX_TIME_S - 1)) begin
						st_nxt = WSB_POST; // R11
						key_nxt = 1'b0;
						post_nxt = 3'd0;
					end
				end
			end
			WSB_CW: begin
				if (dacc_r + 32'(wpm) >= 32'(DIT_LIM)) begin
					dacc_nxt = dacc_r + 32'(wpm) - 32'(DIT_LIM);
					if (cwi_r == cw_last) begin
						st_nxt = WSB_POST;
						key_nxt = 1'b0;
						post_nxt = 3'd0;
					end else begin
						cwi_nxt = cwi_r + 5'd1;
						key_nxt = cwpat_r[cwi_r + 5'd1]; // R22
					end
				end else begin
					dacc_nxt = dacc_r + 32'(wpm);
				end
			end
			WSB_POST: begin
				key_nxt = 1'b0;
				if (sec_tick) begin
					post_nxt = post_r + 3'd1;
					if (post_r == 3'(POST_S - 1)) begin
						st_nxt = WSB_WAIT; // R14
					end
				end
			end
			default: begin
				st_nxt = WSB_OFF;
				key_nxt = 1'b0;
			end
		endcase
		// cancel beats everything; no state is kept to resume from
		if (button_exit) begin
			st_nxt = WSB_OFF; // R18
			key_nxt = 1'b0; // R25
			idx_nxt = 8'd0;
			tone_nxt = 2'd0;
		end
		word_nxt = {freq_r[FREQ_W-1:0], 13'h0} +
			TONE_W'(tone_nxt) * TONE_W'(SPACING_NUM_HZ); // R2 R5
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_r <= WSB_OFF;
			idx_r <= 8'd0;
			tone_r <= 2'd0;
			key_r <= 1'b0;
			sacc_r <= '0;
			tsec_r <= 7'd0;
			nmin_r <= 6'd0;
			post_r <= 3'd0;
			cwi_r <= 5'd0;
			dacc_r <= 32'd0;
			boot_r <= 1'b1;
			word_r <= '0;
		end else if (clk_en) begin
			st_r <= st_nxt;
			idx_r <= idx_nxt;
			tone_r <= tone_nxt;
			key_r <= key_nxt;
			sacc_r <= sacc_nxt;
			tsec_r <= tsec_nxt;
			nmin_r <= nmin_nxt;
			post_r <= post_nxt;
			cwi_r <= cwi_nxt;
			dacc_r <= dacc_nxt;
			boot_r <= boot_nxt;
			word_r <= word_nxt;
		end
	end

	// --------------------------------------------------------------
	// reference measurement against the second pulse
	// --------------------------------------------------------------
	// error is cycles counted between pulses minus nominal; first
	// pulse of the window only arms the counter
	assign meas_on = st_r == WSB_POST && post_r < 3'(MEAS_S); // R13

	always_comb begin
		pps_d_nxt = gps_second_pulse;
		pps_seen_nxt = pps_seen_r;
		pcnt_nxt = pcnt_r + 32'd1;
		perr_nxt = perr_r;
		if (!meas_on) begin
			pps_seen_nxt = 1'b0;
			pcnt_nxt = 32'd0;
		end else if (gps_second_pulse && !pps_d_r) begin
			if (pps_seen_r) begin
				perr_nxt = pcnt_r - 32'(SEC_CYC); // R9
			end
			pps_seen_nxt = 1'b1;
			pcnt_nxt = 32'd1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pps_d_r <= 1'b0;
			pps_seen_r <= 1'b0;
			pcnt_r <= 32'd0;
			perr_r <= 32'd0;
		end else if (clk_en) begin
			pps_d_r <= pps_d_nxt;
			pps_seen_r <= pps_seen_nxt;
			pcnt_r <= pcnt_nxt;
			perr_r <= perr_nxt;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign reg_rdata = rdata_r;
	assign tx_key = key_r; // R20
	assign tone_word = word_r;
	assign sym_idx = idx_r; // R7
	assign sym_tone = tone_r; // R7
	assign beacon_active = st_r != WSB_OFF;
	assign time_hh = hh; // R8
	assign time_mm = mm;
	assign time_ss = ss;
	assign next_min = nmin_r; // R8
	assign ref_err = perr_r;
endmodule // wsb_beacon_sequencer

// *** design/wsb_pkg.sv ***
package wsb_pkg;
	// --------------------------------------------------------------
	// clock and timing
	// --------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int SPACING_NUM_HZ = 12_000;
	localparam int SPACING_DEN = 8_192;
	// symbol time is den/num seconds: acc gains num each cycle,
	// a symbol ends when it reaches clk_hz * den (exact, no drift)
	localparam longint SYM_ACC_LIM_DEF = longint'(CLK_HZ) * SPACING_DEN;
	localparam int SACC_W = 38;
	localparam int SEC_CYC_DEF = CLK_HZ;
	// dit time is 1.2 s / wpm: acc gains wpm each cycle
	localparam int DIT_MS_WPM = 1_200;
	localparam int DIT_LIM_DEF = CLK_HZ / 1_000 * DIT_MS_WPM;
	localparam int TX_TIME_S = 112;
	localparam int POST_S = 7;
	localparam int MEAS_S = 4;
	localparam int SYM_COUNT = 162;
	localparam int FREQ_W = 28;
	localparam int TONE_W = FREQ_W + 13;
	// --------------------------------------------------------------
	// register offsets and reset values
	// --------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_FREQ = 8'h04;
	localparam logic [7:0] A_CALL_HI = 8'h08;
	localparam logic [7:0] A_CALL_LO = 8'h0C;
	localparam logic [7:0] A_GRID = 8'h10;
	localparam logic [7:0] A_POWER = 8'h14;
	localparam logic [7:0] A_SYMW = 8'h18;
	localparam logic [7:0] A_CWPAT = 8'h1C;
	localparam logic [7:0] A_CWCFG = 8'h20;
	localparam logic [7:0] A_TIME = 8'h24;
	localparam logic [7:0] A_STATUS = 8'h28;
	localparam logic [7:0] A_REFERR = 8'h2C;
	localparam logic [31:0] CTRL_RST = 32'h0004_0A00;
	localparam logic [31:0] FREQ_RST = 32'h00D7_1AF4;
	localparam logic [31:0] POWER_RST = 32'h0000_0025;
	localparam logic [31:0] CWCFG_RST = 32'h0000_1407;
	localparam logic [7:0] GPS_SYNC = 8'h24;
	// --------------------------------------------------------------
	// sequencer states
	// --------------------------------------------------------------
	typedef enum logic [2:0] {
		WSB_OFF,
		WSB_WAIT,
		WSB_WSPR,
		WSB_CW,
		WSB_POST
	} wsb_state_e;

	function automatic logic [5:0] wsb_add_min(logic [5:0] a,
		logic [5:0] b);
		logic [6:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= 7'd60) begin
			s = s - 7'd60;
		end
		return s[5:0];
	endfunction
endpackage

// *** design/wsb_gps_if.sv ***
`timescale 1ns/1ps
interface wsb_gps_if;
	logic parse_en;
	logic upd;
	logic [4:0] hh;
	logic [5:0] mm;
	logic [5:0] ss;
	logic [31:0] grid;
	modport parser (input parse_en, output upd, hh, mm, ss, grid);
	modport core (output parse_en, input upd, hh, mm, ss, grid);
endinterface

// *** design/wsb_rtc.sv ***
`timescale 1ns/1ps
module wsb_rtc #(
	parameter int SEC_CYC = wsb_pkg::SEC_CYC_DEF
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic set,
	input wire logic [4:0] set_hh,
	input wire logic [5:0] set_mm,
	input wire logic load,
	input wire logic [4:0] load_hh,
	input wire logic [5:0] load_mm,
	input wire logic [5:0] load_ss,
	output logic [4:0] hh_r,
	output logic [5:0] mm_r,
	output logic [5:0] ss_r,
	output logic tick_r
);
	import wsb_pkg::*;
	logic [31:0] sub_r, sub_nxt;
	logic [4:0] hh_nxt;
	logic [5:0] mm_nxt, ss_nxt;
	logic tick_nxt;

	always_comb begin
		sub_nxt = sub_r + 32'd1;
		hh_nxt = hh_r;
		mm_nxt = mm_r;
		ss_nxt = ss_r;
		tick_nxt = 1'b0;
		if (set) begin
			hh_nxt = set_hh;
			mm_nxt = set_mm;
			ss_nxt = 6'd0;
			sub_nxt = 32'd0;
		end else if (load) begin
			hh_nxt = load_hh;
			mm_nxt = load_mm;
			ss_nxt = load_ss;
			sub_nxt = 32'd0;
		end else if (sub_r >= 32'(SEC_CYC - 1)) begin
			sub_nxt = 32'd0;
			tick_nxt = 1'b1;
			ss_nxt = ss_r + 6'd1;
			if (ss_r == 6'd59) begin
				ss_nxt = 6'd0;
				mm_nxt = wsb_add_min(mm_r, 6'd1);
				if (mm_r == 6'd59) begin
					hh_nxt = (hh_r == 5'd23) ? 5'd0 : hh_r + 5'd1;
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			sub_r <= 32'd0;
			hh_r <= 5'd0;
			mm_r <= 6'd0;
			ss_r <= 6'd0;
			tick_r <= 1'b0;
		end else if (clk_en) begin
			sub_r <= sub_nxt;
			hh_r <= hh_nxt;
			mm_r <= mm_nxt;
			ss_r <= ss_nxt;
			tick_r <= tick_nxt;
		end
	end
endmodule // wsb_rtc

// *** design/wsb_gps_parser.sv ***
`timescale 1ns/1ps
module wsb_gps_parser (
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic gps_valid,
	input wire logic [7:0] gps_byte,
	wsb_gps_if.parser gif
);
	import wsb_pkg::*;
	logic [2:0] cnt_r, cnt_nxt;
	logic [7:0] b_r [0:4];
	logic [7:0] b_nxt [0:4];
	logic upd_nxt;
	logic [31:0] grid_nxt;

	// lon is degrees east plus 180, lat is degrees north plus 90
	function automatic logic [31:0] grid_of(logic [8:0] lon,
		logic [7:0] lat);
		logic [7:0] f1, s1, f2, s2;
		f1 = 8'h41 + 8'(lon / 9'd20);
		s1 = 8'h30 + 8'((lon % 9'd20) / 9'd2);
		f2 = 8'h41 + lat / 8'd10;
		s2 = 8'h30 + lat % 8'd10;
		return {f1, f2, s1, s2};
	endfunction

	// frame: sync, hh, mm, ss, lon_hi, lon_lo, lat
	always_comb begin
		cnt_nxt = cnt_r;
		b_nxt = b_r;
		upd_nxt = 1'b0;
		grid_nxt = gif.grid;
		if (!gif.parse_en) begin
			cnt_nxt = 3'd0; // R12
		end else if (gps_valid) begin
			if (cnt_r == 3'd0) begin
				cnt_nxt = (gps_byte == GPS_SYNC) ? 3'd1 : 3'd0;
			end else if (cnt_r == 3'd6) begin
				cnt_nxt = 3'd0;
				upd_nxt = 1'b1;
				grid_nxt = grid_of({b_r[3][0], b_r[4]}, gps_byte); // R10
			end else begin
				b_nxt[cnt_r - 3'd1] = gps_byte;
				cnt_nxt = cnt_r + 3'd1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_r <= 3'd0;
			b_r <= '{default: 8'h00};
			gif.upd <= 1'b0;
			gif.grid <= 32'h0;
		end else if (clk_en) begin
			cnt_r <= cnt_nxt;
			b_r <= b_nxt;
			gif.upd <= upd_nxt;
			gif.grid <= grid_nxt;
		end
	end

	assign gif.hh = b_r[0][4:0];
	assign gif.mm = b_r[1][5:0];
	assign gif.ss = b_r[2][5:0];
endmodule // wsb_gps_parser

// *** verif/wsb_properties.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checks for the beacon sequencer
// ------------------------------------------------------------
module wsb_properties
	import wsb_pkg::*;
#(
	parameter longint SYM_ACC_LIM = wsb_pkg::SYM_ACC_LIM_DEF,
	parameter int SEC_CYC = wsb_pkg::SEC_CYC_DEF,
	parameter int DIT_LIM = wsb_pkg::DIT_LIM_DEF
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic button_exit,
	input wire logic menu_exit,
	input wire logic beacon_enable_nv,
	input wire logic gps_valid,
	input wire logic [7:0] gps_byte,
	input wire logic gps_second_pulse,
	input wire logic tx_key,
	input wire logic [wsb_pkg::TONE_W-1:0] tone_word,
	input wire logic [7:0] sym_idx,
	input wire logic [1:0] sym_tone,
	input wire logic beacon_active,
	input wire logic [4:0] time_hh,
	input wire logic [5:0] time_mm,
	input wire logic [5:0] time_ss,
	input wire logic [5:0] next_min,
	input wire logic [31:0] ref_err
);
	localparam int SYM_CYC = int'(SYM_ACC_LIM / SPACING_NUM_HZ);
	// 32-bit run counter: a full-rate message is billions of cycles
	logic [7:0] idx_q_r, idx_q_nxt;
	logic [31:0] gap_r, gap_nxt, run_r, run_nxt;
	always_comb begin
		idx_q_nxt = sym_idx;
		gap_nxt = (sym_idx != idx_q_r) ? 32'h1 : gap_r + 32'h1;
		run_nxt = tx_key ? run_r + 32'h1 : 32'h0;
	end
	always_ff @(posedge clock) begin
		if (rst) begin
			idx_q_r <= 8'h00;
			gap_r <= 32'h0;
			run_r <= 32'h0;
		end else begin
			idx_q_r <= idx_q_nxt;
			gap_r <= gap_nxt;
			run_r <= run_nxt;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	chk_cancel_unkey: assert property (
		clk_en && button_exit |=> !tx_key && !beacon_active
		&& sym_idx == 8'h00 && sym_tone == 2'h0)
		else $error("cancel left the sequencer running");
	chk_idle_unkeyed: assert property (!beacon_active |-> !tx_key)
		else $error("keyed while beacon is off");
	chk_idx_range: assert property (sym_idx <= 8'hA1)
		else $error("symbol index past last symbol");
	chk_idx_step: assert property (
		tx_key && $past(tx_key) && sym_idx != $past(sym_idx)
		|-> sym_idx == $past(sym_idx) + 8'h01 || sym_idx == 8'h00)
		else $error("symbol index skipped");
	chk_sym_period: assert property (
		tx_key && sym_idx != idx_q_r && sym_idx >= 8'h02
		|-> gap_r == SYM_CYC)
		else $error("symbol period wrong");
	chk_key_length: assert property (
		$fell(tx_key) && $past(sym_idx) == 8'hA1
		|-> run_r == TX_TIME_S * SEC_CYC)
		else $error("message keyed time wrong");
	chk_slot_start: assert property (
		tx_key && !$past(tx_key) && next_min != $past(next_min)
		|-> time_ss == 6'h00 && time_mm == $past(next_min))
		else $error("send began off its slot");
	chk_tone_hold: assert property (
		tx_key && $past(tx_key) && $stable(sym_idx)
		|-> $stable(sym_tone) && $stable(tone_word))
		else $error("tone changed within a symbol");
	chk_tone_step: assert property (
		tx_key && $past(tx_key) && $changed(sym_tone)
		|-> 48'(tone_word) + 48'($past(sym_tone)) * SPACING_NUM_HZ
		== 48'($past(tone_word)) + 48'(sym_tone) * SPACING_NUM_HZ)
		else $error("tone spacing wrong");
	chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	cover property ($rose(tx_key) && sym_idx == 8'h00);
	cover property (button_exit && tx_key);
	cover property ($fell(tx_key) && $past(sym_idx) == 8'hA1);
endmodule // wsb_properties

bind wsb_beacon_sequencer wsb_properties #(.SYM_ACC_LIM(SYM_ACC_LIM),
	.SEC_CYC(SEC_CYC), .DIT_LIM(DIT_LIM)) u_props (.*);

// *** verif/wsb_gps_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// gps receiver: byte stream and second mark
// ------------------------------------------------------------
module wsb_gps_model
	import wsb_pkg::*;
#(
	parameter int SEC_CYC = 200
) (
	input wire logic clock,
	output logic gps_valid,
	output logic [7:0] gps_byte,
	output logic gps_second_pulse
);
	int pps_cnt;
	// only attached while the unit runs as a beacon
	initial begin
		gps_valid = 1'b0;
		gps_byte = 8'hA5;
		gps_second_pulse = 1'b0;
		pps_cnt = 0;
	end
	// mark rises once a second, phase unrelated to the device clock
	always @(posedge clock) begin
		pps_cnt <= (pps_cnt == SEC_CYC - 1) ? 0 : pps_cnt + 1;
		gps_second_pulse <= (pps_cnt < SEC_CYC / 4);
	end
	task automatic send_byte(input logic [7:0] b);
		@(posedge clock);
		gps_byte <= b;
		gps_valid <= 1'b1;
		@(posedge clock);
		gps_valid <= 1'b0;
		// no stale byte once the strobe is gone
		gps_byte <= ~b;
	endtask
	task automatic send_frame(input logic [4:0] hh, input logic [5:0] mm,
		input logic [5:0] ss, input logic [8:0] lon, input logic [7:0] lat);
		send_byte(GPS_SYNC);
		send_byte({3'h0, hh});
		send_byte({2'h0, mm});
		send_byte({2'h0, ss});
		send_byte({7'h00, lon[8]});
		send_byte(lon[7:0]);
		send_byte(lat);
	endtask
endmodule // wsb_gps_model

// *** verif/wsb_beacon_sequencer_tb_top.sv ***
`timescale 1ns/1ps
module wsb_beacon_sequencer_tb_top;
	import wsb_pkg::*;
	// short counts: 10-cycle symbols and units, 200-cycle seconds
	localparam longint SYM_LIM = 64'h1D4C0;
	localparam int SEC = 200;
	localparam logic [31:0] M = 32'hFFFF_FFFF;
	logic clock, rst, clk_en, reg_wr, reg_rd, button_exit, menu_exit;
	logic beacon_enable_nv, gps_valid, gps_second_pulse, tx_key;
	logic beacon_active;
	logic [7:0] reg_addr, gps_byte, sym_idx;
	logic [31:0] reg_wdata, reg_rdata, ref_err;
	logic [TONE_W-1:0] tone_word;
	logic [1:0] sym_tone;
	logic [4:0] time_hh;
	logic [5:0] time_mm, time_ss, next_min;
	int failures, compares;
	longint t_rise;
	wsb_beacon_sequencer #(.SYM_ACC_LIM(SYM_LIM), .SEC_CYC(SEC),
		.DIT_LIM(200)) dut (.*);
	wsb_gps_model #(.SEC_CYC(SEC + 2)) gps (.clock(clock),
		.gps_valid(gps_valid),
		.gps_byte(gps_byte), .gps_second_pulse(gps_second_pulse));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [1:0] tone_of(input int i);
		return 2'(i) ^ 2'(i >> 2);
	endfunction
	function automatic logic [63:0] tw(input logic [1:0] t);
		return 64'(FREQ_RST[27:0]) * 64'h2000 + 64'(t) * SPACING_NUM_HZ;
	endfunction
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		check(64'(reg_rdata & m), 64'(e));
	endtask
	task automatic cancel();
		@(posedge clock);
		button_exit <= 1'b1;
		@(posedge clock);
		button_exit <= 1'b0;
		#1;
	endtask
	task automatic menu_done();
		@(posedge clock);
		menu_exit <= 1'b1;
		@(posedge clock);
		menu_exit <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask
	// bounded waits; a timeout shows up as a mismatch
	task automatic wait_key(input logic lvl, input int lim);
		for (int n = 0; n < lim && tx_key !== lvl; n++) begin
			@(posedge clock);
			#1;
		end
		check(64'(tx_key), 64'(lvl));
	endtask
	task automatic sym_chk(input int k);
		for (int n = 0; n < 2000 && sym_idx !== 8'(k); n++) begin
			@(posedge clock);
			#1;
		end
		check(64'(sym_idx), 64'(k));
		check(64'(sym_tone), 64'(tone_of(k)));
		check(64'(tone_word), tw(tone_of(k)));
	endtask
	task automatic final_report();
		if (failures == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge clock);
		failures++;
		final_report();
	end
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		clk_en = 1'b1;
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		button_exit = 1'b0;
		menu_exit = 1'b0;
		beacon_enable_nv = 1'b1;
		failures = 0;
		compares = 0;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1;
		check(64'(beacon_active), 64'h1);
		rd(A_CTRL, M, CTRL_RST);
		rd(A_FREQ, M, FREQ_RST);
		rd(A_POWER, M, POWER_RST);
		rd(A_CWCFG, M, CWCFG_RST);
		check(64'(next_min), 64'h4);
		wr(A_CALL_LO, 32'h4142_4344);
		rd(A_CALL_LO, M, 32'h4142_4344);
		rd(8'h30, M, 32'h0);
		wr(A_STATUS, M);
		rd(A_STATUS, 32'h7, 32'h1);
		for (int i = 0; i < SYM_COUNT; i++) begin
			wr(A_SYMW, {8'h00, 8'(i), 14'h0000, tone_of(i)});
		end
		wr(A_TIME, 32'h0000_0300);
		@(posedge clock);
		#1;
		check(64'({time_mm, time_ss}), 64'h0C0);
		wait_key(1'b1, 12500);
		check(64'(time_mm), 64'h4);
		check(64'(next_min), 64'hE);
		for (int k = 0; k < 4; k++) begin
			sym_chk(k);
		end
		cancel();
		check(64'({tx_key, beacon_active, sym_idx}), 64'h0);
		repeat (300) @(posedge clock);
		check(64'(tx_key), 64'h0);
		wr(A_CTRL, 32'h0006_0A00);
		wr(A_TIME, 32'h0000_0500);
		menu_done();
		check(64'({beacon_active, next_min}), 64'h46);
		wait_key(1'b1, 12500);
		t_rise = $time;
		check(64'(time_mm), 64'h6);
		gps.send_frame(5'h05, 6'h05, 6'h05, 9'h00A, 8'h0A);
		sym_chk(161);
		repeat (20) @(posedge clock);
		check(64'({sym_idx, sym_tone}), 64'({8'hA1, tone_of(161)}));
		check(64'(time_hh), 64'h0);
		wait_key(1'b0, 23000);
		check(64'(($time - t_rise) / 40), 64'(TX_TIME_S * SEC));
		rd(A_STATUS, 32'h7, 32'h4);
		gps.send_frame(5'h01, 6'h0A, 6'h14, 9'h0BE, 8'h8D);
		repeat (3) @(posedge clock);
		#1;
		check(64'({time_hh, time_mm}), 64'h4A);
		rd(A_GRID, M, 32'h4A4F_3531);
		repeat (1500) @(posedge clock);
		check(64'(ref_err), 64'h2);
		rd(A_STATUS, 32'h7, 32'h1);
		cancel();
		wr(A_CTRL, 32'h000C_0A01);
		wr(A_CWPAT, 32'h0000_0005);
		wr(A_CWCFG, 32'h0000_1402);
		wr(A_TIME, 32'h0001_0B00);
		menu_done();
		check(64'(next_min), 64'hC);
		wait_key(1'b1, 12500);
		rd(A_STATUS, 32'h7, 32'h3);
		repeat (3) @(posedge clock);
		#1;
		check(64'(tx_key), 64'h1);
		repeat (10) @(posedge clock);
		check(64'(tx_key), 64'h0);
		repeat (10) @(posedge clock);
		check(64'(tx_key), 64'h1);
		final_report();
	end
endmodule // wsb_beacon_sequencer_tb_top
